// File: hdl/table_write_map.vh
`ifndef TABLE_WRITE_MAP_VH
`define TABLE_WRITE_MAP_VH
`define TW_PTR_W 16
`define TW_DATA_W 16
`define TW_QPH_W 2
`define TW_Q_DECODE 2'h0
`define TW_Q_READ 2'h1
`define TW_Q_EXEC 2'h2
`define TW_Q_WRITE 2'h3
`define TW_CLK_NS 4
`define TW_PROG_TIME_NS 1000
`define TW_PROG_CYCLES 16'h00fa
`define TW_PROG_CNT_W 16
`define TW_NORMAL_CYCLES 2
`define TW_INT_BASE_RESET 16'he000
`endif

// File: hdl/quarter_phase_gen.v
`timescale 1ns/10ps
`include "table_write_map.vh"
module quarter_phase_gen (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Phase
  output reg [`TW_QPH_W-1:0] phase_out,
  output reg cycle_end_out
);
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      phase_out <= `TW_Q_DECODE;
      cycle_end_out <= 1'b0;
    end else begin
      phase_out <= phase_out + 2'h1;
      cycle_end_out <= (phase_out == `TW_Q_EXEC);
    end
  end
endmodule // quarter_phase_gen

// File: hdl/table_write_sequencer.v
`timescale 1ns/10ps
`include "table_write_map.vh"
module table_write_sequencer #(
  parameter [`TW_PROG_CNT_W-1:0] PROG_CYCLES = `TW_PROG_CYCLES,
  parameter [`TW_PTR_W-1:0] INT_BASE = `TW_INT_BASE_RESET
) (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Instruction request
  input wire start_in,
  input wire incr_sel_in,
  input wire [`TW_DATA_W-1:0] src_data_in,
  input wire ptr_load_in,
  input wire [`TW_PTR_W-1:0] ptr_value_in,
  // System pins
  input wire interrupt_in,
  input wire reset_programming_pin_in,
  // Memory side
  output reg mem_we_out,
  output reg prog_pulse_out,
  output reg [`TW_PTR_W-1:0] mem_addr_out,
  output reg [`TW_DATA_W-1:0] mem_data_out,
  // Status
  output reg [`TW_PTR_W-1:0] table_pointer_out,
  output reg busy_out,
  output reg done_out,
  output reg aborted_out,
  output reg prog_ok_out
);
  // One-hot sequencer states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CYC1 = 4'h2;
  localparam [3:0] ST_CYC2 = 4'h4;
  localparam [3:0] ST_PROG = 4'h8;
  // Pins from outside the clock domain: bit 0 interrupt, bit 1 programming voltage
  localparam integer N_PINS = 2;
  localparam [`TW_PROG_CNT_W-1:0] CNT_ONE = {{(`TW_PROG_CNT_W-1){1'b0}}, 1'b1};

  // Quarter phase
  wire [`TW_QPH_W-1:0] phase;
  wire cycle_end;

  // Sequencer registers and next values
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [`TW_PROG_CNT_W-1:0] cnt_q;
  reg [`TW_PROG_CNT_W-1:0] cnt_d;
  reg incr_q;
  reg incr_d;
  reg internal_q;
  reg internal_d;

  // Next values of the output flops
  reg mem_we_d;
  reg prog_pulse_d;
  reg [`TW_PTR_W-1:0] mem_addr_d;
  reg [`TW_DATA_W-1:0] mem_data_d;
  reg [`TW_PTR_W-1:0] table_pointer_d;
  reg busy_d;
  reg done_d;
  reg aborted_d;
  reg prog_ok_d;

  // Synchronised pins
  wire [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_stable;
  wire irq_s;
  wire vpp_s;

  // Decoded conditions
  wire take;
  wire to_internal;
  wire prog_last;
  wire [`TW_PTR_W-1:0] ptr_next;

  quarter_phase_gen u_phase (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .phase_out(phase),
    .cycle_end_out(cycle_end)
  );

  // Three-stage pin sync, change accepted when last two agree
  assign pin_raw = {reset_programming_pin_in, interrupt_in};
  genvar g;
  generate
    for (g = 0; g < N_PINS; g = g + 1) begin : g_pin_sync
      reg [2:0] sync_q;
      reg stable_q;
      always @(posedge clk_in) begin
        if (!resetn_in) begin
          sync_q <= 3'h0;
          stable_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], pin_raw[g]};
          if (sync_q[2] == sync_q[1])
            stable_q <= sync_q[2];
        end
      end
      assign pin_stable[g] = stable_q;
    end
  endgenerate
  assign irq_s = pin_stable[0];
  assign vpp_s = pin_stable[1];

  // Request taken only in the decode quarter of an idle cycle
  assign take = (state_q == ST_IDLE) && start_in && (phase == `TW_Q_DECODE);
  assign to_internal = (table_pointer_out >= INT_BASE);
  assign prog_last = (cnt_q == CNT_ONE);
  assign ptr_next = table_pointer_out + {{(`TW_PTR_W-1){1'b0}}, incr_q};

  // Next state and next output values
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    incr_d = incr_q;
    internal_d = internal_q;
    mem_we_d = 1'b0;
    prog_pulse_d = prog_pulse_out;
    mem_addr_d = mem_addr_out;
    mem_data_d = mem_data_out;
    table_pointer_d = table_pointer_out;
    busy_d = busy_out;
    done_d = 1'b0;
    aborted_d = 1'b0;
    prog_ok_d = prog_ok_out;
    case (state_q)
      ST_IDLE: begin
        if (ptr_load_in)
          table_pointer_d = ptr_value_in;
        if (take) begin
          state_d = ST_CYC1;
          busy_d = 1'b1;
          incr_d = incr_sel_in;
          internal_d = to_internal;
          mem_addr_d = table_pointer_out;
        end
      end
      ST_CYC1: begin
        if (phase == `TW_Q_READ)
          mem_data_d = src_data_in;
        if (cycle_end)
          state_d = ST_CYC2;
      end
      ST_CYC2: begin
        if (phase == `TW_Q_WRITE) begin
          if (internal_q) begin
            state_d = ST_PROG;
            cnt_d = PROG_CYCLES;
            prog_pulse_d = 1'b1;
            prog_ok_d = vpp_s;
          end else begin
            state_d = ST_IDLE;
            mem_we_d = 1'b1;
            busy_d = 1'b0;
            done_d = 1'b1;
            table_pointer_d = ptr_next;
          end
        end
      end
      ST_PROG: begin
        cnt_d = cnt_q - CNT_ONE;
        // Voltage lost mid-write: location may be disturbed, never reported good
        if (!vpp_s)
          prog_ok_d = 1'b0;
        if (irq_s || prog_last) begin
          state_d = ST_IDLE;
          prog_pulse_d = 1'b0;
          busy_d = 1'b0;
          done_d = ~irq_s;
          aborted_d = irq_s;
          // Write not committed when cut short by the interrupt
          if (irq_s)
            prog_ok_d = 1'b0;
          table_pointer_d = ptr_next;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
        prog_pulse_d = 1'b0;
      end
    endcase
  end

  // Sequencer state
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      cnt_q <= {`TW_PROG_CNT_W{1'b0}};
      incr_q <= 1'b0;
      internal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      incr_q <= incr_d;
      internal_q <= internal_d;
    end
  end

  // Output flops
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      mem_we_out <= 1'b0;
      prog_pulse_out <= 1'b0;
      mem_addr_out <= {`TW_PTR_W{1'b0}};
      mem_data_out <= {`TW_DATA_W{1'b0}};
      table_pointer_out <= {`TW_PTR_W{1'b0}};
      busy_out <= 1'b0;
      done_out <= 1'b0;
      aborted_out <= 1'b0;
      prog_ok_out <= 1'b0;
    end else begin
      mem_we_out <= mem_we_d;
      prog_pulse_out <= prog_pulse_d;
      mem_addr_out <= mem_addr_d;
      mem_data_out <= mem_data_d;
      table_pointer_out <= table_pointer_d;
      busy_out <= busy_d;
      done_out <= done_d;
      aborted_out <= aborted_d;
      prog_ok_out <= prog_ok_d;
    end
  end
endmodule // table_write_sequencer

// File: testbench/table_memory_model.sv
`timescale 1ns/10ps
module table_memory_model (
  input wire clk_in,
  input wire mem_we_out,
  input wire [15:0] mem_addr_out,
  input wire [15:0] mem_data_out
);
  reg [15:0] mem_q [0:255];
  always @(posedge clk_in) begin
    if (mem_we_out) mem_q[mem_addr_out[7:0]] <= mem_data_out;
  end
endmodule // table_memory_model

// File: testbench/table_write_sequencer_asserts.sv
`timescale 1ns/10ps
module tws_chk #(parameter [15:0] INT_BASE = 16'he000) (
  input wire clk_in, resetn_in, incr_sel_in, interrupt_in, reset_programming_pin_in,
  input wire mem_we_out, prog_pulse_out, busy_out, done_out, aborted_out, prog_ok_out,
  input wire [15:0] mem_addr_out, table_pointer_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire ext = mem_addr_out < INT_BASE;
  ext_write_a: assert property ($rose(busy_out) && ext |-> ##7 mem_we_out && done_out)
    else $error("late write");
  prog_start_a: assert property ($rose(busy_out) && !ext |-> ##7 prog_pulse_out)
    else $error("late program");
  ptr_step_a: assert property (done_out |-> table_pointer_out == mem_addr_out + incr_sel_in)
    else $error("bad pointer");
  irq_cut_a: assert property ($rose(interrupt_in) && prog_pulse_out |-> ##[1:8] aborted_out)
    else $error("no abort");
  no_vpp_a: assert property ((prog_pulse_out && !reset_programming_pin_in)[*8] |-> !prog_ok_out)
    else $error("bad prog ok");
  cover property (done_out && ext);
  cover property (aborted_out);
  cover property (done_out && prog_ok_out);
endmodule // tws_chk
bind table_write_sequencer tws_chk #(.INT_BASE(INT_BASE)) chk_u (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .incr_sel_in(incr_sel_in),
  .interrupt_in(interrupt_in),
  .reset_programming_pin_in(reset_programming_pin_in),
  .mem_we_out(mem_we_out),
  .prog_pulse_out(prog_pulse_out),
  .busy_out(busy_out),
  .done_out(done_out),
  .aborted_out(aborted_out),
  .prog_ok_out(prog_ok_out),
  .mem_addr_out(mem_addr_out),
  .table_pointer_out(table_pointer_out)
);

// File: testbench/table_write_sequencer_test.sv
`timescale 1ns/10ps
module table_write_sequencer_test;
  reg clk_in = 0, resetn_in = 0, start_in = 0, incr_sel_in = 0, ptr_load_in = 0, ab = 0;
  reg interrupt_in = 0, reset_programming_pin_in = 1;
  reg [15:0] src_data_in = 16'h0, ptr_value_in = 16'h0;
  wire mem_we_out, prog_pulse_out, busy_out, done_out, aborted_out, prog_ok_out;
  wire [15:0] mem_addr_out, mem_data_out, table_pointer_out;
  integer num_errors = 0, n_checks = 0, seed = 32'hd5a1, i, k;
  reg [31:0] rnd = 32'h0;
  function [15:0] exp_ptr(input [15:0] a, input c);
    begin
      exp_ptr = a + {15'h0, c};
    end
  endfunction
  function [15:0] exp_status(input q, input vpp);
    begin
      exp_status = {14'h0, q, !q && vpp};
    end
  endfunction
  always #2 clk_in = ~clk_in;
  table_write_sequencer #(.PROG_CYCLES(16'h0028)) dut_u (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(start_in),
    .incr_sel_in(incr_sel_in),
    .src_data_in(src_data_in),
    .ptr_load_in(ptr_load_in),
    .ptr_value_in(ptr_value_in),
    .interrupt_in(interrupt_in),
    .reset_programming_pin_in(reset_programming_pin_in),
    .mem_we_out(mem_we_out),
    .prog_pulse_out(prog_pulse_out),
    .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out),
    .table_pointer_out(table_pointer_out),
    .busy_out(busy_out),
    .done_out(done_out),
    .aborted_out(aborted_out),
    .prog_ok_out(prog_ok_out)
  );
  table_memory_model mem_u (
    .clk_in(clk_in),
    .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out)
  );
  task chk(input [15:0] g, e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0t %h %h", $time, g, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task op(input [15:0] a, input c, q);
    begin
      ptr_load_in = 1;
      ptr_value_in = a;
      @(negedge clk_in) ptr_load_in = 0;
      start_in = 1;
      incr_sel_in = c;
      rnd = $random(seed);
      src_data_in = rnd[15:0];
      for (k = 0; k < 9 && !busy_out; k = k + 1) @(negedge clk_in);
      chk({15'h0, busy_out}, 16'h0001);
      start_in = 0;
      for (k = 0; k < 90 && !done_out && !aborted_out; k = k + 1) begin
        @(negedge clk_in) interrupt_in = q && k > 12;
      end
      ab = aborted_out;
      chk({15'h0, done_out | aborted_out}, 16'h0001);
      @(negedge clk_in) interrupt_in = 0;
      chk(table_pointer_out, exp_ptr(a, c));
      if (a < 16'he000) chk(mem_u.mem_q[a[7:0]], src_data_in);
      else chk({14'h0, ab, prog_ok_out}, exp_status(q, reset_programming_pin_in));
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_in);
    resetn_in = 1;
    for (i = 0; i < 14; i = i + 1) begin
      reset_programming_pin_in = i % 4 != 3;
      rnd = $random(seed);
      op(i == 0 ? 16'hdfff : i == 1 ? 16'hffff : i[0] ? rnd[15:0] | 16'he000 : rnd[15:0],
        i < 2 ? 1'b1 : rnd[16], i % 3 == 2);
      @(negedge clk_in);
    end
    stop_test;
  end
  initial begin
    #20000;
    num_errors = num_errors + 1;
    stop_test;
  end
endmodule // table_write_sequencer_test
